// ==== rtl/gpcb_bank.sv ====
// configuration bank: converter clock, pad muxing, pull-ups, die id unlock
module gpcb_bank #(
  parameter int unsigned DIVIDER_W = gpcb_pkg::DIV_W
) (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire gpcb_pkg::gpcb_bus_req_type bus_req,
  output gpcb_pkg::gpcb_bus_rsp_type     bus_rsp,
  input  wire logic                      sleep_pin,
  input  wire logic                      slow_clock_pin,
  input  wire logic [1:0]                fast_clock_freq_select,
  input  wire logic                      adc_clock_request,
  input  wire logic [63:0]               die_identifier,
  output logic                           adc_clock_tick,
  output gpcb_pkg::gpcb_pad_type         pad_cfg,
  output gpcb_pkg::gpcb_pullup_type      pullup_cfg,
  output logic                           eeprom_read_unlocked
);
  import gpcb_pkg::*;

  if (FAST_DIV_SEL3 >= (1 << DIVIDER_W) || DEFAULT_DIVISOR >= (1 << DIVIDER_W)) begin : bad_w
    $error("divider width cannot hold divisors");
  end

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic in_bank(input logic [7:0] addr);
    return addr >= ADDR_ADC_CLOCK_CTRL && addr <= ADDR_READ_UNLOCK;
  endfunction : in_bank

  function automatic logic [2:0] bank_index(input logic [7:0] addr);
    return 3'(addr - ADDR_ADC_CLOCK_CTRL);
  endfunction : bank_index

  function automatic logic in_die_id(input logic [7:0] addr);
    return addr >= ADDR_DIE_ID_FIRST && addr <= ADDR_DIE_ID_LAST;
  endfunction : in_die_id

  function automatic logic [DIVIDER_W-1:0] fast_divisor(input logic [1:0] sel);
    case (sel)
      2'h1:    return DIVIDER_W'(FAST_DIV_SEL1);
      2'h2:    return DIVIDER_W'(FAST_DIV_SEL2);
      2'h3:    return DIVIDER_W'(FAST_DIV_SEL3);
      default: return '0;
    endcase
  endfunction : fast_divisor

  // ****************************************************************
  // register bank and read port
  // ****************************************************************
  logic [BANK_SIZE-1:0][7:0] bank;
  logic [BANK_SIZE-1:0][7:0] next_bank;
  gpcb_bus_rsp_type          next_rsp;
  logic [7:0]                read_value;
  logic [7:0]                die_byte;
  logic [2:0]                die_index;
  logic                      unlocked;

  assign unlocked  = bank[IDX_READ_UNLOCK] == UNLOCK_PATTERN;
  assign die_index = 3'(bus_req.addr - ADDR_DIE_ID_FIRST);
  assign die_byte  = die_identifier[die_index*8 +: 8];

  // read mux, die bytes hidden while locked
  always_comb begin
    read_value = 8'h00;
    if (in_bank(bus_req.addr)) begin
      read_value = bank[bank_index(bus_req.addr)];
    end else if (in_die_id(bus_req.addr) && unlocked) begin
      read_value = die_byte;
    end
  end

  // whole-byte writes, reserved bits stored too
  always_comb begin
    next_bank = bank;
    next_rsp  = '{valid: 1'b0, data: 8'h00};
    if (bus_req.write && in_bank(bus_req.addr)) begin
      next_bank[bank_index(bus_req.addr)] = bus_req.wdata;
    end
    if (bus_req.read) begin
      next_rsp.valid = 1'b1;
      next_rsp.data  = read_value;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bank    <= BANK_RESET;
      bus_rsp <= '{valid: 1'b0, data: 8'h00};
    end else begin
      bank    <= next_bank;
      bus_rsp <= next_rsp;
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] sleep_sync;
  logic [2:0] next_sleep_sync;
  logic [2:0] slow_sync;
  logic [2:0] next_slow_sync;
  logic       sleep_state;
  logic       next_sleep_state;
  logic       slow_level;
  logic       next_slow_level;
  logic       slow_tick;
  logic       next_slow_tick;

  // level accepted once second and third stage agree
  always_comb begin
    next_sleep_sync  = {sleep_sync[1:0], sleep_pin};
    next_slow_sync   = {slow_sync[1:0], slow_clock_pin};
    next_sleep_state = sleep_state;
    next_slow_level  = slow_level;
    next_slow_tick   = 1'b0;
    if (sleep_sync[1] == sleep_sync[2]) begin
      next_sleep_state = sleep_sync[2];
    end
    if (slow_sync[1] == slow_sync[2]) begin
      next_slow_level = slow_sync[2];
      next_slow_tick  = slow_sync[2] && !slow_level;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sleep_sync  <= 3'h0;
      slow_sync   <= 3'h0;
      sleep_state <= 1'b0;
      slow_level  <= 1'b0;
      slow_tick   <= 1'b0;
    end else begin
      sleep_sync  <= next_sleep_sync;
      slow_sync   <= next_slow_sync;
      sleep_state <= next_sleep_state;
      slow_level  <= next_slow_level;
      slow_tick   <= next_slow_tick;
    end
  end

  // ****************************************************************
  // converter clock dividers and selection
  // ****************************************************************
  logic [7:0] adc_cfg;
  logic       adc_fast_divider_enable;
  logic       adc_slow_divider_enable;
  logic       battery_monitor_sleep_enable;
  logic       default_clock_enable;
  logic       fast_tick;
  logic       slow_div_tick;
  logic       default_tick;
  logic       next_adc_tick;

  assign adc_cfg                      = bank[IDX_ADC_CLOCK_CTRL];
  assign adc_fast_divider_enable      = adc_cfg[BIT_FAST_DIV_EN] && !sleep_state;
  assign adc_slow_divider_enable      = adc_cfg[BIT_SLOW_DIV_EN];
  assign battery_monitor_sleep_enable = adc_cfg[BIT_SLEEP_SLOW_SEL];
  assign default_clock_enable         = adc_cfg[BIT_DEFAULT_CLK_EN];

  gpcb_divider #(.WIDTH(DIVIDER_W)) u_fast_div (
    .clock    (clock),
    .resetn   (resetn),
    .enable   (adc_fast_divider_enable),
    .tick_in  (1'b1),
    .divisor  (fast_divisor(fast_clock_freq_select)),
    .tick_out (fast_tick)
  );

  gpcb_divider #(.WIDTH(DIVIDER_W)) u_slow_div (
    .clock    (clock),
    .resetn   (resetn),
    .enable   (adc_slow_divider_enable),
    .tick_in  (slow_tick),
    .divisor  (DIVIDER_W'(SLOW_DIVISOR)),
    .tick_out (slow_div_tick)
  );

  gpcb_divider #(.WIDTH(DIVIDER_W)) u_default_div (
    .clock    (clock),
    .resetn   (resetn),
    .enable   (default_clock_enable),
    .tick_in  (1'b1),
    .divisor  (DIVIDER_W'(DEFAULT_DIVISOR)),
    .tick_out (default_tick)
  );

  // default clock bypasses request gating; else source by sleep state
  always_comb begin
    next_adc_tick = 1'b0;
    if (default_clock_enable) begin
      next_adc_tick = default_tick;
    end else if (adc_clock_request) begin
      if (sleep_state) begin
        next_adc_tick = battery_monitor_sleep_enable && adc_slow_divider_enable
                        && slow_div_tick;
      end else begin
        next_adc_tick = adc_fast_divider_enable && fast_tick;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      adc_clock_tick <= 1'b0;
    end else begin
      adc_clock_tick <= next_adc_tick;
    end
  end

  // ****************************************************************
  // pad muxing, pull-ups and unlock outputs
  // ****************************************************************
  gpcb_pad_type    next_pad;
  gpcb_pullup_type next_pullup;
  logic [1:0]      pad_mode;

  assign pad_mode = bank[IDX_PAD_MUX_USB][PAD_MODE_LSB +: 2];

  // decode pad mode into pad ownership
  always_comb begin
    next_pad.usb_rx_on_data6 = 1'b0;
    case (pad_mode)
      PAD_MODE_USB3: begin
        next_pad.gpio_pad_enable     = GPIO_MASK_USB3;
        next_pad.usb_data_pad_enable = USB_MASK_USB3;
      end
      PAD_MODE_USB4: begin
        next_pad.gpio_pad_enable     = GPIO_MASK_USB4;
        next_pad.usb_data_pad_enable = USB_MASK_USB4;
      end
      PAD_MODE_USB4_RX6: begin
        next_pad.gpio_pad_enable     = GPIO_MASK_USB4_RX6;
        next_pad.usb_data_pad_enable = USB_MASK_USB4_RX6;
        next_pad.usb_rx_on_data6     = 1'b1;
      end
      default: begin
        next_pad.gpio_pad_enable     = GPIO_MASK_FULL_USB;
        next_pad.usb_data_pad_enable = USB_MASK_FULL;
      end
    endcase
    next_pad.pin8_serial_rx_select = bank[IDX_PAD_MUX_UART][BIT_SERIAL_RX_SEL];
    next_pad.led_sync_function     = bank[IDX_READ_UNLOCK][BIT_LED_SYNC_SEL];
    next_pullup.aux_bus_data_pullup_en   = bank[IDX_I2C_PULLUP][BIT_AUX_DATA_PU];
    next_pullup.aux_bus_clock_pullup_en  = bank[IDX_I2C_PULLUP][BIT_AUX_CLOCK_PU];
    next_pullup.main_bus_data_pullup_en  = bank[IDX_I2C_PULLUP][BIT_MAIN_DATA_PU];
    next_pullup.main_bus_clock_pullup_en = bank[IDX_I2C_PULLUP][BIT_MAIN_CLOCK_PU];
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pad_cfg              <= '{gpio_pad_enable: GPIO_MASK_FULL_USB,
                                usb_data_pad_enable: USB_MASK_FULL, default: 1'b0};
      pullup_cfg           <= '{default: 1'b1};
      eeprom_read_unlocked <= 1'b0;
    end else begin
      pad_cfg              <= next_pad;
      pullup_cfg           <= next_pullup;
      eeprom_read_unlocked <= unlocked;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  unlock_gate_a : assert property (
    (bus_req.read && in_die_id(bus_req.addr) && !unlocked)
      |=> (bus_rsp.valid && bus_rsp.data == 8'h00))
    else $error("die byte returned while locked");

  unlock_open_a : assert property (
    (bus_req.read && in_die_id(bus_req.addr) && unlocked)
      |=> (bus_rsp.valid && bus_rsp.data == $past(die_byte)))
    else $error("die byte wrong while unlocked");

  unlock_flag_a : assert property (
    (bus_req.write && bus_req.addr == ADDR_READ_UNLOCK && bus_req.wdata == UNLOCK_PATTERN)
      |=> ##1 (eeprom_read_unlocked && pad_cfg.led_sync_function))
    else $error("unlock pattern did not unlock");

  default_bypass_a : assert property (
    (default_clock_enable && default_tick && !adc_clock_request) |=> adc_clock_tick)
    else $error("default clock gated by request");

  no_clock_a : assert property (
    (!default_clock_enable && !adc_cfg[BIT_FAST_DIV_EN] && !adc_cfg[BIT_SLOW_DIV_EN])
      |=> !adc_clock_tick)
    else $error("converter clock without any source");

  sleep_source_a : assert property (
    (sleep_state && !default_clock_enable
      && !(battery_monitor_sleep_enable && adc_slow_divider_enable)) |=> !adc_clock_tick)
    else $error("converter clock in sleep without slow source");

  freq_zero_a : assert property (
    (!default_clock_enable && !sleep_state && fast_clock_freq_select == 2'h0)
      [*2] |=> !adc_clock_tick)
    else $error("converter clock with zero frequency select");

  pad_mode3_a : assert property (
    (pad_mode == PAD_MODE_USB4_RX6)
      |=> (pad_cfg.usb_rx_on_data6 && pad_cfg.usb_data_pad_enable == USB_MASK_USB4_RX6
           && pad_cfg.gpio_pad_enable == GPIO_MASK_USB4_RX6))
    else $error("pad mode 3 decode wrong");

  spare_readback_a : assert property (
    (bus_req.write && bus_req.addr == ADDR_PAD_MUX_UART) ##1 !bus_req.write
      ##1 (bus_req.read && !bus_req.write && bus_req.addr == ADDR_PAD_MUX_UART)
      |=> (bus_rsp.data == $past(bus_req.wdata, 3)))
    else $error("spare bits did not read back");

  unlocked_read_c : cover property (
    bus_req.read && in_die_id(bus_req.addr) && unlocked);
  sleep_tick_c : cover property (sleep_state && adc_clock_tick);
  default_tick_c : cover property (default_clock_enable && adc_clock_tick);
  fast_tick_c : cover property (!default_clock_enable && !sleep_state && adc_clock_tick);

endmodule : gpcb_bank

// ==== common/gpcb_pkg.sv ====
// constants, field layout and carrier types of the configuration bank
package gpcb_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_DIE_ID_FIRST   = 8'h89;
  localparam logic [7:0] ADDR_DIE_ID_LAST    = 8'h90;
  localparam logic [7:0] ADDR_ADC_CLOCK_CTRL = 8'h91;
  localparam logic [7:0] ADDR_PAD_MUX_USB    = 8'h92;
  localparam logic [7:0] ADDR_PAD_MUX_UART   = 8'h93;
  localparam logic [7:0] ADDR_I2C_PULLUP     = 8'h94;
  localparam logic [7:0] ADDR_SPARE_PULL_A   = 8'h95;
  localparam logic [7:0] ADDR_SPARE_PULL_B   = 8'h96;
  localparam logic [7:0] ADDR_READ_UNLOCK    = 8'h97;
  localparam int unsigned BANK_SIZE          = 7;
  localparam logic [2:0] IDX_ADC_CLOCK_CTRL  = 3'h0;
  localparam logic [2:0] IDX_PAD_MUX_USB     = 3'h1;
  localparam logic [2:0] IDX_PAD_MUX_UART    = 3'h2;
  localparam logic [2:0] IDX_I2C_PULLUP      = 3'h3;
  localparam logic [2:0] IDX_READ_UNLOCK     = 3'h6;

  // reset values, index 6 first
  localparam logic [BANK_SIZE-1:0][7:0] BANK_RESET =
    {8'h00, 8'h00, 8'h50, 8'h55, 8'h00, 8'h00, 8'h90};

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned BIT_FAST_DIV_EN    = 7;
  localparam int unsigned BIT_SLOW_DIV_EN    = 6;
  localparam int unsigned BIT_SLEEP_SLOW_SEL = 5;
  localparam int unsigned BIT_DEFAULT_CLK_EN = 4;
  localparam int unsigned BIT_SERIAL_RX_SEL  = 1;
  localparam int unsigned BIT_LED_SYNC_SEL   = 0;
  localparam int unsigned BIT_AUX_DATA_PU    = 6;
  localparam int unsigned BIT_AUX_CLOCK_PU   = 4;
  localparam int unsigned BIT_MAIN_DATA_PU   = 2;
  localparam int unsigned BIT_MAIN_CLOCK_PU  = 0;
  localparam int unsigned PAD_MODE_LSB       = 0;
  localparam logic [7:0] UNLOCK_PATTERN      = 8'h49;

  // ****************************************************************
  // pad modes and pad masks
  // ****************************************************************
  localparam logic [1:0]  PAD_MODE_FULL_USB  = 2'h0;
  localparam logic [1:0]  PAD_MODE_USB3      = 2'h1;
  localparam logic [1:0]  PAD_MODE_USB4      = 2'h2;
  localparam logic [1:0]  PAD_MODE_USB4_RX6  = 2'h3;
  localparam logic [15:0] GPIO_MASK_FULL_USB = 16'h0000;
  localparam logic [15:0] GPIO_MASK_USB3     = 16'h5e38;
  localparam logic [15:0] GPIO_MASK_USB4     = 16'h4e38;
  localparam logic [15:0] GPIO_MASK_USB4_RX6 = 16'h5e28;
  localparam logic [7:0]  USB_MASK_FULL      = 8'hff;
  localparam logic [7:0]  USB_MASK_USB3      = 8'h07;
  localparam logic [7:0]  USB_MASK_USB4      = 8'h0f;
  localparam logic [7:0]  USB_MASK_USB4_RX6  = 8'h47;

  // ****************************************************************
  // converter clock divisors
  // ****************************************************************
  localparam int unsigned DIV_W           = 6;
  localparam int unsigned DEFAULT_DIVISOR = 26;
  localparam int unsigned SLOW_DIVISOR    = 3;
  localparam int unsigned FAST_DIV_SEL1   = 19;
  localparam int unsigned FAST_DIV_SEL2   = 26;
  localparam int unsigned FAST_DIV_SEL3   = 38;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpcb_bus_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } gpcb_bus_rsp_type;

  typedef struct packed {
    logic [15:0] gpio_pad_enable;
    logic [7:0]  usb_data_pad_enable;
    logic        usb_rx_on_data6;
    logic        pin8_serial_rx_select;
    logic        led_sync_function;
  } gpcb_pad_type;

  typedef struct packed {
    logic aux_bus_data_pullup_en;
    logic aux_bus_clock_pullup_en;
    logic main_bus_data_pullup_en;
    logic main_bus_clock_pullup_en;
  } gpcb_pullup_type;

endpackage : gpcb_pkg

// ==== rtl/gpcb_divider.sv ====
// tick divider: one output pulse per divisor input pulses
module gpcb_divider #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             enable,
  input  wire logic             tick_in,
  input  wire logic [WIDTH-1:0] divisor,
  output logic                  tick_out
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_tick;

  if (WIDTH < 2) begin : bad_width
    $error("divider width too small");
  end

  // count input ticks, zero divisor stops the divider
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (!enable || divisor == '0) begin
      next_count = '0;
    end else if (tick_in) begin
      if (count >= WIDTH'(divisor - 1'b1)) begin
        next_count = '0;
        next_tick  = 1'b1;
      end else begin
        next_count = WIDTH'(count + 1'b1);
      end
    end
  end

  // register state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else begin
      count    <= next_count;
      tick_out <= next_tick;
    end
  end

endmodule : gpcb_divider

// ==== verification/gpcb_host_model.sv ====
// host model: issues byte writes and reads to the configuration bank
module gpcb_host_model (
  input  wire gpcb_pkg::gpcb_bus_rsp_type bus_rsp,
  input  wire logic                       clock,
  output gpcb_pkg::gpcb_bus_req_type      bus_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpcb_pkg::*;

  // ********
  // bus idle at time zero
  // ********
  initial begin
    bus_req = '0;
  end

  // one write strobe; address and data scrambled once released
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    bus_req <= {1'b1, 1'b0, addr, data};
    @(negedge clock);
    bus_req <= {1'b0, 1'b0, ~addr, ~data};
  endtask : write_reg

  // one read strobe; answer taken while valid stands
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    bus_req <= {1'b0, 1'b1, addr, 8'h00};
    @(negedge clock);
    bus_req <= {1'b0, 1'b0, ~addr, 8'hff};
    data = (bus_rsp.valid === 1'b1) ? bus_rsp.data : 8'hxx;
  endtask : read_reg
endmodule : gpcb_host_model

// ==== verification/testbench.sv ====
// self-checking bench of the configuration bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpcb_pkg::*;

  logic              clock;
  logic              resetn;
  logic              sleep_pin;
  logic              slow_clock_pin;
  logic [1:0]        fast_clock_freq_select;
  logic              adc_clock_request;
  logic [63:0]       die_identifier;
  logic              adc_clock_tick;
  logic              eeprom_read_unlocked;
  gpcb_bus_req_type  bus_req;
  gpcb_bus_rsp_type  bus_rsp;
  gpcb_pad_type      pad_cfg;
  gpcb_pullup_type   pullup_cfg;
  int                fail_count;
  int                n_compared;

  // ********
  // clocks: 20 MHz main, free 3 MHz slow source
  // ********
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    slow_clock_pin = 1'b0;
    forever #167 slow_clock_pin = ~slow_clock_pin;
  end

  gpcb_host_model host (.clock(clock), .bus_rsp(bus_rsp), .bus_req(bus_req));

  gpcb_bank dut (
    .clock                  (clock),
    .resetn                 (resetn),
    .bus_req                (bus_req),
    .bus_rsp                (bus_rsp),
    .sleep_pin              (sleep_pin),
    .slow_clock_pin         (slow_clock_pin),
    .fast_clock_freq_select (fast_clock_freq_select),
    .adc_clock_request      (adc_clock_request),
    .die_identifier         (die_identifier),
    .adc_clock_tick         (adc_clock_tick),
    .pad_cfg                (pad_cfg),
    .pullup_cfg             (pullup_cfg),
    .eeprom_read_unlocked   (eeprom_read_unlocked)
  );

  // ********
  // compare and helper tasks
  // ********
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_span(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("Error at %0t: period %h expected %h..%h", $time, got, lo, hi);
    end
  endtask : check_span

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(addr, d);
    check({8'h00, d}, {8'h00, exp});
  endtask : rd_check

  // cycles between two converter ticks, 0 when none comes
  task automatic measure(output int period);
    int n;
    period = 0;
    n = 0;
    repeat (12) @(negedge clock);
    while (adc_clock_tick !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    if (n < 100) begin
      n = 0;
      do begin
        @(negedge clock);
        n++;
      end while (adc_clock_tick !== 1'b1 && n < 100);
      if (n < 100) period = n;
    end
  endtask : measure

  // ********
  // scenarios
  // ********
  task automatic t_reset;
    logic [7:0] rst [7] = '{8'h90, 8'h00, 8'h00, 8'h55, 8'h50, 8'h00, 8'h00};
    int p;
    for (int i = 0; i < 7; i++) rd_check(8'h91 + 8'(i), rst[i]);
    check(pad_cfg.gpio_pad_enable, 16'h0000);
    check({8'h00, pad_cfg.usb_data_pad_enable}, 16'h00ff);
    check({12'h000, pullup_cfg}, 16'h000f);
    check({15'h0000, eeprom_read_unlocked}, 16'h0000);
    measure(p);
    check_span(p, 26, 26);
    $display("reset values test done");
  endtask : t_reset

  // every register bit written both ways, each read one idle cycle after its write
  task automatic t_store;
    for (int i = 0; i < 7; i++) begin
      host.write_reg(8'h91 + 8'(i), 8'ha5);
      rd_check(8'h91 + 8'(i), 8'ha5);
      host.write_reg(8'h91 + 8'(i), 8'h5a);
      rd_check(8'h91 + 8'(i), 8'h5a);
    end
    host.write_reg(8'h98, 8'hff);
    rd_check(8'h98, 8'h00);
    rd_check(8'h96, 8'h5a);
    $display("storage test done");
  endtask : t_store

  task automatic t_pads;
    logic [15:0] gm [4] = '{16'h0000, 16'h5e38, 16'h4e38, 16'h5e28};
    logic [7:0] um [4] = '{8'hff, 8'h07, 8'h0f, 8'h47};
    for (int m = 0; m < 4; m++) begin
      host.write_reg(8'h92, 8'(m));
      repeat (2) @(negedge clock);
      check(pad_cfg.gpio_pad_enable, gm[m]);
      check({8'h00, pad_cfg.usb_data_pad_enable}, {8'h00, um[m]});
      check({15'h0000, pad_cfg.usb_rx_on_data6}, 16'(m == 3));
    end
    host.write_reg(8'h93, 8'h02);
    repeat (2) @(negedge clock);
    check({15'h0000, pad_cfg.pin8_serial_rx_select}, 16'h0001);
    host.write_reg(8'h93, 8'hf0);
    repeat (2) @(negedge clock);
    check({15'h0000, pad_cfg.pin8_serial_rx_select}, 16'h0000);
    host.write_reg(8'h94, 8'h44);
    repeat (2) @(negedge clock);
    check({12'h000, pullup_cfg}, 16'h000a);
    host.write_reg(8'h94, 8'h11);
    repeat (2) @(negedge clock);
    check({12'h000, pullup_cfg}, 16'h0005);
    $display("pad and pull-up test done");
  endtask : t_pads

  task automatic t_unlock;
    host.write_reg(8'h97, 8'h00);
    rd_check(8'h89, 8'h00);
    host.write_reg(8'h97, 8'h49);
    for (int k = 0; k < 8; k++) rd_check(8'h89 + 8'(k), die_identifier[8*k +: 8]);
    check({14'h0000, eeprom_read_unlocked, pad_cfg.led_sync_function}, 16'h0003);
    host.write_reg(8'h97, 8'h01);
    rd_check(8'h90, 8'h00);
    check({14'h0000, eeprom_read_unlocked, pad_cfg.led_sync_function}, 16'h0001);
    host.write_reg(8'h97, 8'h48);
    repeat (2) @(negedge clock);
    check({15'h0000, pad_cfg.led_sync_function}, 16'h0000);
    $display("unlock test done");
  endtask : t_unlock

  // register, select, request, sleep, period low, period high
  task automatic t_clock;
    int cfg [11][6] = '{'{'h80, 0, 1, 0, 0, 0}, '{'h80, 1, 1, 0, 19, 19},
      '{'h80, 2, 1, 0, 26, 26}, '{'h80, 3, 1, 0, 38, 38}, '{'h80, 2, 0, 0, 0, 0},
      '{'h00, 2, 1, 0, 0, 0}, '{'ha0, 1, 1, 0, 19, 19}, '{'he0, 1, 1, 1, 19, 21},
      '{'hc0, 1, 1, 1, 0, 0}, '{'h80, 1, 1, 1, 0, 0}, '{'h10, 0, 0, 0, 26, 26}};
    int p;
    for (int i = 0; i < 11; i++) begin
      @(negedge clock);
      fast_clock_freq_select = 2'(cfg[i][1]);
      adc_clock_request = cfg[i][2][0];
      sleep_pin = cfg[i][3][0];
      host.write_reg(8'h91, 8'(cfg[i][0]));
      measure(p);
      check_span(p, cfg[i][4], cfg[i][5]);
    end
    $display("converter clock test done");
  endtask : t_clock

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // ********
  // main sequence and watchdog
  // ********
  initial begin
    fail_count = 0;
    n_compared = 0;
    resetn = 1'b0;
    sleep_pin = 1'b0;
    fast_clock_freq_select = 2'h0;
    adc_clock_request = 1'b0;
    die_identifier = 64'h8877_6655_4433_2211;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    t_reset();
    t_store();
    t_pads();
    t_unlock();
    t_clock();
    wrap_up();
  end
  initial begin
    #500us;
    fail_count++;
    $display("Error at %0t: watchdog %h expected %h", $time, 1'b1, 1'b0);
    wrap_up();
  end
endmodule : testbench
